// ---- verilog/lcs_pkg.sv ----
/*
  Shared constants, the switch carrier type and the LED decode for the
  LED current switch sequencer.
  Assumes 8-bit register data and 6-bit register addresses.
*/
package lcs_pkg;
  // Register addresses
  localparam logic [5:0] ADDR_TEST_MODE   = 6'h01;
  localparam logic [5:0] ADDR_SOFT_RESET  = 6'h04;
  localparam logic [5:0] ADDR_EXT_PAGE    = 6'h24;
  localparam logic [5:0] ADDR_SEQ_RESET   = 6'h2f;

  // Data codes
  localparam logic [7:0] CODE_TEST_ENTER  = 8'ha3;
  localparam logic [7:0] CODE_TEST_EXIT   = 8'h23;
  localparam logic [7:0] CODE_BLANK_DIS   = 8'h1c;
  localparam logic [7:0] CODE_RESET       = 8'h00;

  // Reset values
  localparam logic [7:0] TEST_MODE_RST    = 8'h00;
  localparam logic [7:0] EXT_PAGE_RST     = 8'h00;
  localparam logic [7:0] DAC_ZERO         = 8'h00;
  localparam logic [1:0] SEQ_FIRST        = 2'h0;

  // LED selection codes
  localparam logic [1:0] LED_OFF          = 2'h0;
  localparam logic [1:0] LED_RED          = 2'h1;
  localparam logic [1:0] LED_GREEN        = 2'h2;
  localparam logic [1:0] LED_BLUE         = 2'h3;

  // Cycles the DAC is given to settle at zero and at the new value
  localparam logic [3:0] DAC_SETTLE_LAST  = 4'h7;

  typedef struct packed {
    logic [2:0] rgb;
    logic       shunt;
    logic [7:0] dac;
  } lcs_sw_t;

  localparam lcs_sw_t SW_RST = '{rgb: 3'h0, shunt: 1'b1, dac: 8'h00};

  // RGB matrix switch pattern, bit 0 red, bit 1 green, bit 2 blue
  function automatic logic [2:0] lcs_led_rgb(input logic [1:0] led);
    case (led)
      LED_RED:   lcs_led_rgb = 3'h1;
      LED_GREEN: lcs_led_rgb = 3'h2;
      LED_BLUE:  lcs_led_rgb = 3'h4;
      default:   lcs_led_rgb = 3'h0;
    endcase
  endfunction : lcs_led_rgb
endpackage : lcs_pkg

// ---- verilog/lcs_pwm.sv ----
/*
  PWM timing for the LED drive: clock divider enable, period counter and
  duty compare.
  Assumes a clean synchronous restart from the owner whenever a new
  sequence state begins.
*/
`timescale 1ns/100ps
module lcs_pwm
  import lcs_pkg::*;
#(
  parameter int CW = 12
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          restart,
  input  wire logic [3:0]    clk_div,
  input  wire logic [CW-1:0] period,
  input  wire logic [CW-1:0] duty,
  output logic               pwm_on,
  output logic               wrap
);
  logic [3:0]    div_q;
  logic [CW-1:0] cnt_q;
  logic          on_q;
  logic          tick;
  logic          at_end;

  assign tick   = (div_q == clk_div);
  assign at_end = tick && (cnt_q == period);
  assign pwm_on = on_q;
  assign wrap   = at_end;

  always_ff @(posedge clk) begin
    if (rst || restart) begin
      div_q <= 4'h0;
      cnt_q <= '0;
      on_q  <= 1'b0;
    end else begin
      div_q <= tick ? 4'h0 : div_q + 4'h1;
      if (tick) begin
        cnt_q <= at_end ? '0 : cnt_q + 1'b1;
      end
      on_q <= (cnt_q < duty);
    end
  end

  a_pwm_wrap_end: assert property (@(posedge clk) disable iff (rst)
    wrap |=> (cnt_q == '0))
    else $error("PWM count did not return to zero after the period");
endmodule : lcs_pwm

// ---- verilog/lcs_switch_seq.sv ----
/*
  Switch and DAC sequencer: slew controlled state transitions through the
  shunt path and current steering for PWM pulsing.
  Assumes the owner holds change_req until ack and keeps new_led/new_dac
  stable while it is high.
*/
`timescale 1ns/100ps
module lcs_switch_seq
  import lcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       blank_dis,
  input  wire logic       change_req,
  input  wire logic [1:0] new_led,
  input  wire logic [7:0] new_dac,
  input  wire logic       pwm_on,
  output logic            ack,
  output logic            busy,
  output lcs_sw_t         sw
);
  typedef enum logic [2:0] {SW_IDLE, SW_SHUNT, SW_OPEN, SW_ZERO, SW_LOAD,
                            SW_MAKE, SW_BREAK} lcs_sw_st_t;

  lcs_sw_st_t st_q, st_d;
  lcs_sw_t    sw_q, sw_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] led_q, led_d;
  logic [7:0] tgt_q, tgt_d;
  logic [2:0] led_rgb;
  logic       want_on;

  assign led_rgb = lcs_led_rgb(led_q);
  assign want_on = pwm_on && (led_q != LED_OFF);
  assign ack     = change_req && (st_q == SW_IDLE);
  assign busy    = (st_q != SW_IDLE);
  assign sw      = sw_q;

  // One switch action per clock keeps every overlap visible for a cycle
  always_comb begin
    st_d  = st_q;
    sw_d  = sw_q;
    cnt_d = cnt_q;
    led_d = led_q;
    tgt_d = tgt_q;
    case (st_q)
      SW_IDLE: begin
        if (change_req) begin
          led_d = new_led;
          tgt_d = new_dac;
          st_d  = blank_dis ? SW_MAKE : SW_SHUNT;
        end else if (want_on) begin
          if (sw_q.rgb != led_rgb) begin
            sw_d.rgb = led_rgb;
          end else begin
            sw_d.shunt = 1'b0;
          end
        end else begin
          if (!sw_q.shunt) begin
            sw_d.shunt = 1'b1;
          end else begin
            sw_d.rgb = 3'h0;
          end
        end
      end
      SW_SHUNT: begin
        sw_d.shunt = 1'b1;
        st_d       = SW_OPEN;
      end
      SW_OPEN: begin
        sw_d.rgb = 3'h0;
        sw_d.dac = DAC_ZERO;
        cnt_d    = 4'h0;
        st_d     = SW_ZERO;
      end
      SW_ZERO: begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == DAC_SETTLE_LAST) begin
          sw_d.dac = tgt_q;
          cnt_d    = 4'h0;
          st_d     = SW_LOAD;
        end
      end
      SW_LOAD: begin
        cnt_d = cnt_q + 4'h1;
        // New LED closes, then the shunt opens, through the steering path
        if (cnt_q == DAC_SETTLE_LAST) begin
          st_d = SW_IDLE;
        end
      end
      SW_MAKE: begin
        sw_d.rgb   = sw_q.rgb | led_rgb;
        sw_d.shunt = sw_q.shunt | (led_q == LED_OFF);
        sw_d.dac   = tgt_q;
        st_d       = SW_BREAK;
      end
      SW_BREAK: begin
        sw_d.rgb = sw_q.rgb & led_rgb;
        st_d     = SW_IDLE;
      end
      default: begin
        st_d = SW_IDLE;
        sw_d = SW_RST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q  <= SW_IDLE;
      sw_q  <= SW_RST;
      cnt_q <= 4'h0;
      led_q <= LED_OFF;
      tgt_q <= DAC_ZERO;
    end else begin
      st_q  <= st_d;
      sw_q  <= sw_d;
      cnt_q <= cnt_d;
      led_q <= led_d;
      tgt_q <= tgt_d;
    end
  end

  a_path_always: assert property (@(posedge clk) disable iff (rst)
    sw_q.shunt || (sw_q.rgb != 3'h0))
    else $error("DAC current left with no conducting path");

  a_dac_dark: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && $changed(sw_q.dac) && !blank_dis |-> sw_q.shunt && (sw_q.rgb == 3'h0))
    else $error("DAC value changed while an LED was lit");

  a_zero_then_load: assert property (@(posedge clk) disable iff (rst)
    (st_q == SW_OPEN) |=> (sw_q.dac == DAC_ZERO) ##8 (sw_q.dac == $past(tgt_q, 1)))
    else $error("DAC not zeroed for the settle time before loading");

  a_break_after_make: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) && $fell(sw_q.rgb != 3'h0) && (st_q == SW_IDLE) |-> $past(sw_q.shunt))
    else $error("LED switch opened before the shunt closed");

  a_one_step: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> !($changed(sw_q.shunt) && $changed(sw_q.rgb)))
    else $error("Shunt and matrix switches changed in the same clock");
endmodule : lcs_switch_seq

// ---- verilog/lcs_led_current_switch_sequencer.sv ----
/*
  LED current switch sequencer top: register writes for the test
  configuration and the two recovery resets, pin synchronisers, sequence
  position, per-colour selection and the switch and PWM engines.
  Assumes a register port fed by the serial interface, one write per
  REG_WR pulse, and the analogue DAC and switches driven directly.
*/
// Summary of operation
// - 8-bit DAC with per-colour range select
// - PWM period and per-colour duty counts
// - Current and PWM set separately per colour
// - Timing from restart, line pulse, clock
// - State transition on LED or DAC change
// - Colour transitions at line start only
// - DAC goes to zero before new value; with blanking disabled SW_MAKE loads the new value directly
// - Shunt closes, old opens, new closes, shunt opens; with blanking disabled new closes, then old opens (SW_MAKE, SW_BREAK)
// - DAC changes only with LEDs dark; with blanking disabled by 0x1C it loads in SW_MAKE while an LED may be lit
// - 0xA3 to 0x01 enters test configuration
// - 0x1C to 0x24 forces red DAC value
// - 0x23 to 0x01 leaves test configuration
// - 0x00 to 0x04 resets whole device
// - 0x00 to 0x2F resets sequencer only
// - Steering: shunt closes before LED opens
// - Make before break keeps DAC path
// - Mono advances on enable period end
// - Restart with line pulse forces state 0
`timescale 1ns/100ps
module lcs_led_current_switch_sequencer
  import lcs_pkg::*;
#(
  parameter int CW = 12
) (
  input  wire logic          REF_CLK,
  input  wire logic          SYS_RST,
  input  wire logic          REG_WR,
  input  wire logic          REG_RD,
  input  wire logic [5:0]    REG_ADDR,
  input  wire logic [7:0]    REG_WDATA,
  output logic      [7:0]    REG_RDATA,
  input  wire logic          LINE_TRANSFER_PULSE,
  input  wire logic          SEQUENCE_RESTART_IN,
  input  wire logic          MONO_MODE,
  input  wire logic [1:0]    SEQ_LAST_STATE,
  input  wire logic [7:0]    STATE_LED_MAP,
  input  wire logic [7:0]    ENABLE_PERIODS,
  input  wire logic [7:0]    RED_DAC_SETTING,
  input  wire logic [7:0]    GREEN_DAC_SETTING,
  input  wire logic [7:0]    BLUE_DAC_SETTING,
  input  wire logic [5:0]    CURRENT_RANGE_SELECT,
  input  wire logic [3:0]    PWM_CLK_DIV,
  input  wire logic [CW-1:0] PWM_PERIOD_COUNT,
  input  wire logic [CW-1:0] RED_DUTY_COUNT,
  input  wire logic [CW-1:0] GREEN_DUTY_COUNT,
  input  wire logic [CW-1:0] BLUE_DUTY_COUNT,
  output logic      [7:0]    LED_CURRENT_DAC,
  output logic      [1:0]    DAC_RANGE,
  output logic      [2:0]    RGB_SWITCH,
  output logic               SHUNT_SWITCH,
  output logic      [1:0]    SEQ_STATE,
  output logic               BLANKING,
  output logic               TEST_CONFIG,
  output logic               BLANK_DISABLED
);
  // Pin synchronisers: bit 0 line pulse, bit 1 restart
  logic [1:0] pin_raw;
  logic [1:0] s1_q, s2_q, s3_q, pin_q;
  logic       line_q;

  assign pin_raw = {SEQUENCE_RESTART_IN, LINE_TRANSFER_PULSE};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
          s1_q[gi]  <= 1'b0;
          s2_q[gi]  <= 1'b0;
          s3_q[gi]  <= 1'b0;
          pin_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            pin_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // Register writes
  logic       soft_rst_q;
  logic       rst_all;
  logic       test_q;
  logic       blank_dis_q;
  logic [7:0] test_reg_q;
  logic [7:0] ext_q;
  logic       seq_rst_q;
  logic       seq_rst_all;
  logic       wr_test, wr_enter, wr_exit, wr_ext, wr_soft, wr_seq;
  logic       normal_wr;

  assign rst_all     = SYS_RST || soft_rst_q;
  assign seq_rst_all = rst_all || seq_rst_q;
  assign wr_test     = REG_WR && (REG_ADDR == ADDR_TEST_MODE);
  assign wr_enter    = wr_test && !test_q && (REG_WDATA == CODE_TEST_ENTER);
  assign wr_exit     = wr_test && test_q && (REG_WDATA == CODE_TEST_EXIT);
  // In test configuration every other write lands on the extended page
  assign wr_ext      = REG_WR && test_q && !wr_exit;
  assign normal_wr   = REG_WR && !test_q;
  assign wr_soft     = normal_wr && (REG_ADDR == ADDR_SOFT_RESET) &&
                       (REG_WDATA == CODE_RESET);
  assign wr_seq      = normal_wr && (REG_ADDR == ADDR_SEQ_RESET) &&
                       (REG_WDATA == CODE_RESET);

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_soft;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (rst_all) begin
      test_q      <= 1'b0;
      test_reg_q  <= TEST_MODE_RST;
      ext_q       <= EXT_PAGE_RST;
      blank_dis_q <= 1'b0;
      seq_rst_q   <= 1'b0;
    end else begin
      seq_rst_q <= wr_seq;
      if (wr_enter) begin
        test_q     <= 1'b1;
        test_reg_q <= REG_WDATA;
      end else if (wr_exit) begin
        test_q     <= 1'b0;
        test_reg_q <= REG_WDATA;
      end else if (normal_wr && wr_test) begin
        test_reg_q <= REG_WDATA;
      end
      if (wr_ext) begin
        ext_q <= REG_WDATA;
      end
      // Stays until SYS_RST or the global soft reset; the sequencer reset keeps it
      if (wr_ext && (REG_WDATA == CODE_BLANK_DIS)) begin
        blank_dis_q <= 1'b1;
      end
    end
  end

  logic [7:0] rdata_q;
  logic [7:0] rd_sel;

  assign rd_sel = (REG_ADDR == ADDR_TEST_MODE) ? test_reg_q :
                  (REG_ADDR == ADDR_EXT_PAGE)  ? ext_q : 8'h00;

  always_ff @(posedge REF_CLK) begin
    if (rst_all) begin
      rdata_q <= 8'h00;
    end else if (REG_RD) begin
      rdata_q <= rd_sel;
    end
  end

  // Sequence position
  logic [1:0] idx_q;
  logic [7:0] wraps_q;
  logic       line_rise;
  logic       restart;
  logic       at_last;
  logic       mono_done;
  logic       advance;
  logic       pwm_wrap;
  logic       pwm_on;
  logic       sw_busy;
  logic       sw_ack;
  logic       pend_q;
  logic       restart_q;
  logic       restart_rise;

  assign line_rise = pin_q[0] && !line_q;
  assign restart   = pin_q[0] && pin_q[1];
  // A held restart must not queue a second, identical transition
  assign restart_rise = restart && !restart_q;
  assign at_last   = (idx_q == SEQ_LAST_STATE);
  assign mono_done = pwm_wrap && !sw_busy && (wraps_q == ENABLE_PERIODS - 8'h01);
  // Colour steps only at a line start; mono steps inside the line
  assign advance   = !at_last && (MONO_MODE ? mono_done : (line_rise && !pin_q[1]));

  always_ff @(posedge REF_CLK) begin
    if (seq_rst_all) begin
      line_q  <= 1'b0;
      idx_q   <= SEQ_FIRST;
      wraps_q <= 8'h00;
      pend_q  <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      line_q <= pin_q[0];
      restart_q <= restart;
      if (restart) begin
        idx_q <= SEQ_FIRST;
      end else if (advance) begin
        idx_q <= idx_q + 2'h1;
      end
      if (restart || advance) begin
        wraps_q <= 8'h00;
      end else if (pwm_wrap && !sw_busy) begin
        wraps_q <= wraps_q + 8'h01;
      end
      // A new request wins over the acknowledge of the previous one
      pend_q <= (restart_rise || advance) || (pend_q && !sw_ack);
    end
  end

  // Per-colour selection
  logic [1:0]    cur_led;
  logic [7:0]    sel_dac;
  logic [7:0]    new_dac;
  logic [CW-1:0] sel_duty;
  lcs_sw_t       sw;

  assign cur_led  = STATE_LED_MAP[{idx_q, 1'b0} +: 2];
  assign sel_dac  = (cur_led == LED_RED)   ? RED_DAC_SETTING :
                    (cur_led == LED_GREEN) ? GREEN_DAC_SETTING :
                    (cur_led == LED_BLUE)  ? BLUE_DAC_SETTING : DAC_ZERO;
  assign new_dac  = blank_dis_q ? RED_DAC_SETTING : sel_dac;
  assign sel_duty = (cur_led == LED_RED)   ? RED_DUTY_COUNT :
                    (cur_led == LED_GREEN) ? GREEN_DUTY_COUNT :
                    (cur_led == LED_BLUE)  ? BLUE_DUTY_COUNT : '0;

  logic [1:0] range_q;

  always_ff @(posedge REF_CLK) begin
    if (rst_all) begin
      range_q <= 2'h0;
    end else if (cur_led != LED_OFF) begin
      range_q <= CURRENT_RANGE_SELECT[{cur_led - 2'h1, 1'b0} +: 2];
    end
  end

  lcs_pwm #(.CW(CW)) u_pwm (
    .clk     (REF_CLK),
    .rst     (seq_rst_all),
    .restart (sw_busy || pend_q),
    .clk_div (PWM_CLK_DIV),
    .period  (PWM_PERIOD_COUNT),
    .duty    (sel_duty),
    .pwm_on  (pwm_on),
    .wrap    (pwm_wrap)
  );

  lcs_switch_seq u_sw (
    .clk        (REF_CLK),
    .rst        (seq_rst_all),
    .blank_dis  (blank_dis_q),
    .change_req (pend_q),
    .new_led    (cur_led),
    .new_dac    (new_dac),
    .pwm_on     (pwm_on),
    .ack        (sw_ack),
    .busy       (sw_busy),
    .sw         (sw)
  );

  assign REG_RDATA       = rdata_q;
  assign LED_CURRENT_DAC = sw.dac;
  assign DAC_RANGE       = range_q;
  assign RGB_SWITCH      = sw.rgb;
  assign SHUNT_SWITCH    = sw.shunt;
  assign SEQ_STATE       = idx_q;
  assign BLANKING        = sw_busy;
  assign TEST_CONFIG     = test_q;
  assign BLANK_DISABLED  = blank_dis_q;

  a_test_enter: assert property (@(posedge REF_CLK) disable iff (rst_all)
    wr_enter |=> test_q && (test_reg_q == CODE_TEST_ENTER))
    else $error("Test configuration not entered");

  a_test_exit: assert property (@(posedge REF_CLK) disable iff (rst_all)
    wr_exit |=> !test_q ##1 !test_q || $past(wr_enter))
    else $error("Test configuration not left");

  a_blank_force: assert property (@(posedge REF_CLK) disable iff (rst_all)
    wr_ext && (REG_WDATA == CODE_BLANK_DIS) |=> blank_dis_q && (new_dac == RED_DAC_SETTING))
    else $error("Blanking disable code did not force the red DAC value");

  a_soft_reset: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    wr_soft |=> ##1 !blank_dis_q && (ext_q == EXT_PAGE_RST) && (idx_q == SEQ_FIRST))
    else $error("Global soft reset did not restore defaults");

  a_seq_reset: assert property (@(posedge REF_CLK) disable iff (rst_all)
    wr_seq |=> ##1 (idx_q == SEQ_FIRST) && $stable(ext_q) && $stable(blank_dis_q))
    else $error("Sequencer reset lost configuration or kept the state");

  a_restart_first: assert property (@(posedge REF_CLK) disable iff (seq_rst_all)
    restart |=> (idx_q == SEQ_FIRST))
    else $error("Restart with line pulse did not return to the first state");

  a_colour_hold: assert property (@(posedge REF_CLK) disable iff (seq_rst_all)
    !MONO_MODE && !line_rise && !restart |=> $stable(idx_q))
    else $error("Colour sequence moved without a line start");

  a_mono_step: assert property (@(posedge REF_CLK) disable iff (seq_rst_all)
    MONO_MODE && mono_done && !at_last && !restart |=> (idx_q == $past(idx_q) + 2'h1))
    else $error("Mono sequence did not step at the end of the enable period");
endmodule : lcs_led_current_switch_sequencer

// ---- dv/lcs_analog_model.sv ----
/*
  Behavioural model of the analogue current DAC, shunt and RGB matrix.
  Assumes the sequencer drives the switches and DAC code directly.
*/
`timescale 1ns/100ps
module lcs_analog_model
  import lcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] rgb,
  input  wire logic       shunt,
  input  wire logic [7:0] dac,
  input  wire logic       blank_dis,
  output logic      [2:0] lit,
  output int              faults
);
  logic [2:0] rgb_q;
  logic       shunt_q;
  logic [7:0] dac_q;
  logic       no_path;
  logic       lit_slew;
  logic       jump;
  logic       multi;
  logic       safe;
  // Closed shunt has the lower impedance, so every LED goes dark
  assign lit      = shunt ? 3'h0 : rgb;
  assign no_path  = !shunt && rgb == 3'h0;
  assign lit_slew = !blank_dis && dac != dac_q && (shunt_q ? 3'h0 : rgb_q) != 3'h0;
  assign jump     = !blank_dis && dac != dac_q && dac != 8'h00 && dac_q != 8'h00;
  assign multi    = ($countones(rgb ^ rgb_q) + int'(shunt != shunt_q)) > 1;
  // Recovery resets snap straight to this dark pattern in one step
  assign safe     = rgb == 3'h0 && shunt && dac == 8'h00;
  initial faults = 0;
  always @(posedge clk) begin
    rgb_q   <= rgb;
    shunt_q <= shunt;
    dac_q   <= dac;
    if (!rst && !safe) begin
      faults <= faults + int'(no_path) + int'(lit_slew) + int'(jump) + int'(multi);
    end
  end
endmodule : lcs_analog_model

// ---- dv/lcs_led_current_switch_sequencer_bench.sv ----
/*
  Self-checking bench: register code table, colour sequence, PWM steering,
  mono mode with blanking disabled, recovery and mid-run reset.
  Assumes the analogue model in the same folder.
*/
`timescale 1ns/100ps
module lcs_led_current_switch_sequencer_bench;
  import lcs_pkg::*;
  typedef struct packed {
    logic       rd;
    logic [5:0] addr;
    logic [7:0] data;
    logic       tc;
    logic       bd;
  } lcs_row_t;
  localparam lcs_row_t ROWS [10] = '{
    '{1'b0, 6'h01, 8'ha3, 1'b1, 1'b0}, '{1'b0, 6'h24, 8'h1c, 1'b1, 1'b1},
    '{1'b0, 6'h01, 8'h23, 1'b0, 1'b1}, '{1'b1, 6'h01, 8'h23, 1'b0, 1'b1},
    '{1'b1, 6'h24, 8'h1c, 1'b0, 1'b1}, '{1'b1, 6'h3e, 8'h00, 1'b0, 1'b1},
    '{1'b0, 6'h04, 8'h55, 1'b0, 1'b1}, '{1'b0, 6'h2f, 8'h00, 1'b0, 1'b1},
    '{1'b0, 6'h04, 8'h00, 1'b0, 1'b0}, '{1'b1, 6'h01, 8'h00, 1'b0, 1'b0}};
  localparam logic [2:0] ERGB [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
  localparam logic [7:0] EDAC [4] = '{8'h40, 8'h80, 8'hc0, 8'h00};
  localparam logic [1:0] ERNG [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
  logic        clk = 0, rst = 1, wr = 0, rd = 0, line = 0, restart = 0, mono = 0;
  logic [5:0]  addr = 6'h00;
  logic [7:0]  wdata = 8'h00, rdata, en_per = 8'h02;
  logic [7:0]  dac_r = 8'h40, dac_g = 8'h80, dac_b = 8'hc0, dac, map = 8'h39;
  logic [11:0] duty_r = 12'h010, duty_g = 12'h010, duty_b = 12'h010;
  logic [1:0]  rng, seq;
  logic [2:0]  rgb, lit;
  logic        shunt, blanking, tc, bd;
  int          fails = 0, n_tests = 0, faults, cnt;

  always #2.5 clk = ~clk;

  lcs_led_current_switch_sequencer #(.CW(12)) uut (
    .REF_CLK(clk), .SYS_RST(rst), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .LINE_TRANSFER_PULSE(line),
    .SEQUENCE_RESTART_IN(restart), .MONO_MODE(mono), .SEQ_LAST_STATE(2'h3),
    .STATE_LED_MAP(map), .ENABLE_PERIODS(en_per), .RED_DAC_SETTING(dac_r),
    .GREEN_DAC_SETTING(dac_g), .BLUE_DAC_SETTING(dac_b), .CURRENT_RANGE_SELECT(6'h27),
    .PWM_CLK_DIV(4'h0), .PWM_PERIOD_COUNT(12'h00f), .RED_DUTY_COUNT(duty_r),
    .GREEN_DUTY_COUNT(duty_g), .BLUE_DUTY_COUNT(duty_b), .LED_CURRENT_DAC(dac),
    .DAC_RANGE(rng), .RGB_SWITCH(rgb), .SHUNT_SWITCH(shunt), .SEQ_STATE(seq),
    .BLANKING(blanking), .TEST_CONFIG(tc), .BLANK_DISABLED(bd));

  lcs_analog_model model (.clk(clk), .rst(rst), .rgb(rgb), .shunt(shunt), .dac(dac),
    .blank_dis(bd), .lit(lit), .faults(faults));

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_op(input logic r, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    rd <= r;
    wr <= !r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : reg_op

  task automatic pins(input logic rs);
    @(posedge clk);
    restart <= rs;
    line <= 1'b1;
    repeat (2) @(posedge clk);
    restart <= 1'b0;
    line <= 1'b0;
  endtask : pins

  // Waits on BLANKING (sel 0) or SEQ_STATE (sel 1), never open-ended
  task automatic wait_for(input logic sel, input logic [1:0] val, input int lim);
    int k;
    k = 0;
    while ((sel ? seq : {1'b0, blanking}) !== val && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= lim) begin
      fails++;
      $display("unexpected wait: expected %h, seen %h", val, sel ? seq : {1'b0, blanking});
      wrap_up();
    end
  endtask : wait_for

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      reg_op(ROWS[i].rd, ROWS[i].addr, ROWS[i].data);
      check("test config", tc, ROWS[i].tc);
      check("blank disabled", bd, ROWS[i].bd);
      if (ROWS[i].rd) check("read data", rdata, ROWS[i].data);
    end
    $display("register table done");
    for (int s = 0; s < 4; s++) begin
      pins(s == 0);
      wait_for(1'b0, 2'h1, 50);
      repeat (2) @(posedge clk);
      #1;
      check("dac blanking", dac, 8'h00);
      check("rgb blanking", rgb, 8'h00);
      wait_for(1'b0, 2'h0, 100);
      repeat (6) @(posedge clk);
      #1;
      check("state", seq, 8'(s));
      check("rgb", rgb, ERGB[s]);
      check("shunt", shunt, s == 3);
      if (s < 3) check("dac", dac, EDAC[s]);
      if (s < 3) check("range", rng, ERNG[s]);
    end
    pins(1'b0);
    repeat (30) @(posedge clk);
    check("held state", seq, 8'h03);
    $display("colour sequence done");
    duty_r <= 12'h008;
    pins(1'b1);
    wait_for(1'b0, 2'h1, 50);
    wait_for(1'b0, 2'h0, 100);
    cnt = 0;
    repeat (64) begin
      @(posedge clk);
      cnt += int'(lit[0]);
    end
    check("red lit window", cnt >= 28 && cnt <= 36, 1'b1);
    $display("pwm steering done");
    duty_r <= 12'h010;
    dac_g <= 8'h40;
    dac_b <= 8'h40;
    mono <= 1'b1;
    reg_op(1'b0, 6'h01, 8'ha3);
    reg_op(1'b0, 6'h24, 8'h1c);
    reg_op(1'b0, 6'h01, 8'h23);
    pins(1'b1);
    wait_for(1'b1, 2'h0, 50);
    wait_for(1'b1, 2'h1, 400);
    repeat (4) @(posedge clk);
    #1;
    check("mono rgb", rgb, 3'h2);
    check("mono dac", dac, 8'h40);
    reg_op(1'b0, 6'h2f, 8'h00);
    check("seq after reset", seq, 8'h00);
    check("kept blank disabled", bd, 1'b1);
    $display("mono and recovery done");
    reg_op(1'b0, 6'h01, 8'ha3);
    check("test config before reset", tc, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("reset test config", tc, 1'b0);
    check("reset blank disabled", bd, 1'b0);
    check("reset rgb", rgb, 8'h00);
    check("reset shunt", shunt, 1'b1);
    check("reset dac", dac, 8'h00);
    check("reset state", seq, 8'h00);
    check("model faults", faults == 0, 1'b1);
    $display("reset done");
    wrap_up();
  end
endmodule : lcs_led_current_switch_sequencer_bench
